// *** pkg/btss_regs.svh ***
`ifndef BTSS_REGS_SVH
`define BTSS_REGS_SVH
// Opcode nibble of the bit test skip when set instruction
`define BTSS_OPCODE        4'hA
// Field positions inside the 16-bit instruction word
`define BTSS_OP_MSB        15
`define BTSS_OP_LSB        12
`define BTSS_BIT_MSB       11
`define BTSS_BIT_LSB       9
`define BTSS_BANKSEL_BIT   8
`define BTSS_FILE_MSB      7
`define BTSS_FILE_LSB      0
// Highest file operand treated as an indexed literal offset
`define BTSS_INDEX_LIMIT   8'h5F
// Access bank split: low part is bank 0, high part is bank 15
`define BTSS_ACCESS_HI_BANK 4'hF
// Flushed cycles after a skip of a one- and a two-word instruction
`define BTSS_FLUSH_ONE     2'h1
`define BTSS_FLUSH_TWO     2'h2
`endif

// *** pkg/btss_pkg.sv ***
package btss_pkg;
  // Decoded fields of the test instruction
  typedef struct packed {
    logic [2:0] bit_index;
    logic       bank_sel;
    logic [7:0] file_addr;
  } btss_fields_t;

  // Data memory request toward the register file
  typedef struct packed {
    logic        valid;
    logic        indexed;
    logic [11:0] addr;
    logic [7:0]  offset;
  } btss_mem_req_t;

  // Executor states
  typedef enum logic [1:0] {
    BTSS_IDLE   = 2'b00,
    BTSS_FLUSH1 = 2'b01,
    BTSS_FLUSH2 = 2'b11
  } btss_state_t;
endpackage : btss_pkg

// *** hw/btss_exec.sv ***
`timescale 1ns/100ps
`include "btss_regs.svh"
// How it works
// RULE1: A one in the tested bit suppresses the next instruction, a zero lets it run.
// RULE2: A skip discards the prefetched word and runs a no-operation, giving two cycles.
// RULE3: Bank select low uses the access bank, high uses the bank select register bank.
// RULE4: Bank select low with the extended set on makes file operands up to 5Fh indexed.
// RULE5: Skipping a two-word instruction costs a further no-operation, three cycles in all.
// RULE6: The instruction is opcode nibble 1010, bit index, bank select and file address.
module btss_exec (
  // Clock and reset
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RESETN_I,
  // Instruction stream, one enable per instruction cycle
  input  wire logic                  CYCLE_EN_I,
  input  wire logic [15:0]           INSTR_I,
  input  wire logic                  NEXT_TWO_WORD_I,
  // Addressing context
  input  wire logic [3:0]            BANK_SELECT_REG_I,
  input  wire logic                  EXT_SET_EN_I,
  // Data memory read path
  output btss_pkg::btss_mem_req_t    MEM_REQ_O,
  input  wire logic [7:0]            MEM_RDATA_I,
  // Pipeline control
  output logic                       HIT_O,
  output logic                       FLUSH_O,
  output logic                       SKIP_DONE_O
);

  btss_pkg::btss_fields_t   fields;
  btss_pkg::btss_mem_req_t  req_next;
  btss_pkg::btss_state_t    state_reg;
  btss_pkg::btss_state_t    state_next;
  logic                     is_test;
  logic                     bit_set;
  logic                     skip_done_reg;
  logic [7:0]               bit_hit;

  // Field split of the incoming word
  assign fields.bit_index = INSTR_I[`BTSS_BIT_MSB:`BTSS_BIT_LSB];
  assign fields.bank_sel  = INSTR_I[`BTSS_BANKSEL_BIT];
  assign fields.file_addr = INSTR_I[`BTSS_FILE_MSB:`BTSS_FILE_LSB];

  // A word in a flush slot is a no-operation, never decoded
  assign is_test = (INSTR_I[`BTSS_OP_MSB:`BTSS_OP_LSB] == `BTSS_OPCODE) // [RULE6]
                   && (state_reg == btss_pkg::BTSS_IDLE);
  assign HIT_O   = is_test;

  // Operand address: indexed, access bank or banked
  always_comb begin
    req_next         = '0;
    req_next.valid   = is_test;
    req_next.offset  = fields.file_addr;
    if (fields.bank_sel) begin
      req_next.addr = {BANK_SELECT_REG_I, fields.file_addr}; // [RULE3]
    end else if (EXT_SET_EN_I && (fields.file_addr <= `BTSS_INDEX_LIMIT)) begin
      req_next.indexed = 1'b1; // [RULE4]
    end else if (fields.file_addr[7]) begin
      req_next.addr = {`BTSS_ACCESS_HI_BANK, fields.file_addr}; // [RULE3]
    end else begin
      req_next.addr = {4'h0, fields.file_addr}; // [RULE3]
    end
  end

  // Request is combinational so the memory answers in the same cycle
  assign MEM_REQ_O = req_next;

  // One match line per bit position, only the indexed one can fire
  for (genvar b = 0; b < 8; b++) begin : g_bit
    assign bit_hit[b] = (fields.bit_index == 3'(b)) && MEM_RDATA_I[b]; // [RULE1]
  end
  assign bit_set   = |bit_hit;

  // Flush sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      btss_pkg::BTSS_IDLE: begin
        if (is_test && bit_set) begin
          state_next = btss_pkg::BTSS_FLUSH1; // [RULE1]
        end
      end
      btss_pkg::BTSS_FLUSH1: begin
        state_next = NEXT_TWO_WORD_I ? btss_pkg::BTSS_FLUSH2 // [RULE5]
                                     : btss_pkg::BTSS_IDLE;  // [RULE2]
      end
      btss_pkg::BTSS_FLUSH2: begin
        state_next = btss_pkg::BTSS_IDLE;
      end
      default: begin
        state_next = btss_pkg::BTSS_IDLE;
      end
    endcase
  end

  // State advances only on instruction cycles
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= btss_pkg::BTSS_IDLE;
    end else if (CYCLE_EN_I) begin
      state_reg <= state_next;
    end
  end

  // Pulse when the last flush cycle ends
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      skip_done_reg <= 1'b0;
    end else begin
      skip_done_reg <= CYCLE_EN_I && (state_reg != btss_pkg::BTSS_IDLE)
                       && (state_next == btss_pkg::BTSS_IDLE);
    end
  end

  // Flush replaces the current word with a no-operation
  assign FLUSH_O     = (state_reg != btss_pkg::BTSS_IDLE); // [RULE2]
  assign SKIP_DONE_O = skip_done_reg;

endmodule : btss_exec

// *** sim/btss_exec_properties.sv ***
`timescale 1ns/100ps
module btss_exec_chk (
  // Clock, reset and inputs
  input wire logic REF_CLK_I, RESETN_I, CYCLE_EN_I, NEXT_TWO_WORD_I, EXT_SET_EN_I,
  input wire logic [15:0] INSTR_I,
  input wire logic [3:0]  BANK_SELECT_REG_I,
  input wire logic [7:0]  MEM_RDATA_I,
  // Outputs watched
  input btss_pkg::btss_mem_req_t MEM_REQ_O,
  input wire logic HIT_O, FLUSH_O, SKIP_DONE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Decoded operand fields, shared by the checks
  wire logic       a_w = INSTR_I[8];
  wire logic [7:0] f_w = INSTR_I[7:0];
  wire logic       ix_w = !a_w && EXT_SET_EN_I && f_w <= 8'h5F;
  AST_DECODE: assert property (HIT_O == (INSTR_I[15:12] == 4'hA && !FLUSH_O))
    else $error("decode mismatch");
  AST_SKIP: assert property (CYCLE_EN_I && HIT_O && MEM_RDATA_I[INSTR_I[11:9]] |=> FLUSH_O)
    else $error("no flush after set bit");
  AST_NO_SKIP: assert property (CYCLE_EN_I && HIT_O && !MEM_RDATA_I[INSTR_I[11:9]] |=> !FLUSH_O)
    else $error("flush after clear bit");
  AST_BANK: assert property (HIT_O && a_w |-> MEM_REQ_O.valid && MEM_REQ_O.addr == {BANK_SELECT_REG_I, f_w})
    else $error("banked address wrong");
  AST_ACCESS: assert property (HIT_O && !a_w && !ix_w |-> MEM_REQ_O.addr == {{4{f_w[7]}}, f_w})
    else $error("access address wrong");
  AST_INDEX: assert property (HIT_O && ix_w |-> MEM_REQ_O.indexed && MEM_REQ_O.offset == f_w)
    else $error("indexed offset wrong");
  AST_TWO_WORD: assert property ($rose(FLUSH_O) && CYCLE_EN_I && NEXT_TWO_WORD_I |=> FLUSH_O)
    else $error("second flush missing");
  AST_DONE: assert property (FLUSH_O && CYCLE_EN_I ##1 !FLUSH_O |-> SKIP_DONE_O)
    else $error("skip done missing");
endmodule : btss_exec_chk
bind btss_exec btss_exec_chk i_chk (.*);

// *** sim/test_btss_exec.sv ***
`timescale 1ns/100ps
module test_btss_exec;
  typedef struct packed {
    logic [15:0] ins; logic [3:0] bank_select_reg; logic ext; logic [7:0] rd;
    logic hit, idx; logic [11:0] adr; logic skp;
  } btss_row_t;
  logic clk = 0, rst_n = 0, en = 1, two = 0, ext = 0;
  logic [15:0] ins = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [7:0]  rd = 8'h00;
  btss_pkg::btss_mem_req_t req;
  logic hit, flush, done;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  btss_row_t rows[7] = '{
    '{16'hA205,4'h0,1'h0,8'h02,1'h1,1'h0,12'h005,1'h1},
    '{16'hA385,4'h3,1'h0,8'h00,1'h1,1'h0,12'h385,1'h0},
    '{16'hAE90,4'h0,1'h1,8'h80,1'h1,1'h0,12'hF90,1'h1},
    '{16'hAE5F,4'h0,1'h1,8'h7F,1'h1,1'h1,12'h000,1'h0},
    '{16'hA060,4'h0,1'h1,8'h01,1'h1,1'h0,12'h060,1'h1},
    '{16'hA15F,4'hA,1'h0,8'hFE,1'h1,1'h0,12'hA5F,1'h0},
    '{16'hB205,4'h0,1'h0,8'h02,1'h0,1'h0,12'h000,1'h0}};
  // Free-running clock
  always #10 clk = ~clk;
  btss_exec i_dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .CYCLE_EN_I(en), .INSTR_I(ins),
    .NEXT_TWO_WORD_I(two), .BANK_SELECT_REG_I(bank_select_reg), .EXT_SET_EN_I(ext), .MEM_REQ_O(req),
    .MEM_RDATA_I(rd), .HIT_O(hit), .FLUSH_O(flush), .SKIP_DONE_O(done));
  task automatic chk(input logic [15:0] seen, exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask : chk
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      fail_count++;
      tally_and_finish;
    end
  end
  // Table rows first, then flush-slot, two-word and reset cases
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    foreach (rows[i]) begin
      {ins, bank_select_reg, ext, rd} = {rows[i].ins, rows[i].bank_select_reg, rows[i].ext, rows[i].rd};
      #1 chk(hit, rows[i].hit, "hit");
      if (rows[i].hit && !rows[i].idx) chk(req.addr, rows[i].adr, "addr");
      chk(req.valid, rows[i].hit, "valid");
      if (rows[i].hit) chk({req.indexed, req.offset}, {rows[i].idx, rows[i].ins[7:0]}, "index");
      @(negedge clk) ins = 16'h0000;
      chk(flush, rows[i].skp, "flush");
      if (rows[i].skp) begin
        @(negedge clk) chk({flush, done}, 2'h1, "skip end");
      end
    end
    @(negedge clk) {ins, bank_select_reg, ext, rd} = {16'hA205, 4'h0, 1'h0, 8'h02};
    @(negedge clk) two = 1;
    #1 chk(hit, 0, "flush slot hit");
    chk(req.valid, 0, "flush slot valid");
    @(negedge clk) two = 0;
    chk(flush, 1, "second flush");
    @(negedge clk) chk({flush, done}, 2'h1, "two word end");
    // Same word tests again; a stalled enable must hold the flush slot
    @(negedge clk) en = 0;
    chk({flush, done}, 2'h2, "done one pulse");
    @(negedge clk) en = 1;
    chk({flush, done}, 2'h2, "stalled flush");
    @(negedge clk) rst_n = 0;
    #1 chk({flush, done}, 2'h0, "reset");
    @(negedge clk) rst_n = 1;
    @(negedge clk) chk(flush, 1, "first test after reset");
    tally_and_finish;
  end
endmodule : test_btss_exec
